// *** asc_consts.svh ***
// constants shared by the add/subtract and compare datapath
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// default operand width and the least width allowed
`define ASC_WIDTH_DEF     8
`define ASC_WIDTH_MIN     2

// levels an unconnected select or carry input falls back to
`define ASC_ADD_SUB_DEF   1'b1
`define ASC_CARRY_IN_DEF  1'b0

// select levels
`define ASC_SEL_ADD       1'b1
`define ASC_SEL_SUB       1'b0

`endif

// *** asc_pkg.sv ***
// types for the add/subtract and compare datapath
package asc_pkg;

    // number representation of the operands
    typedef enum logic [0:0] {
        ASC_REP_UNSIGNED = 1'b0,
        ASC_REP_SIGNED   = 1'b1
    } asc_rep_t;

endpackage

// *** asc_datapath.sv ***
// unsigned adder/subtractor with carry and a magnitude comparator
//
// Function
// RULE1: operands and result share one width, at least two
// RULE2: select high adds, low subtracts, defaults high
// RULE3: carry input takes part, defaults to zero
// RULE4: result is a plus/minus b plus/minus carry
// RULE5: carry output flags unsigned overflow of width
// RULE6: overflow output has no unsigned meaning
// RULE7: representation set explicitly, only unsigned supported; REPRESENTATION defaults to unsigned when not set
// RULE8: sums above the maximum wrap modulo the width
// RULE9: less-than high exactly when a below b
// RULE10: equal high exactly when operands match
// RULE11: greater-than high exactly when a above b
// RULE12: outputs purely combinational, nothing is registered
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_datapath
    import asc_pkg::*;
#(
    parameter int       WIDTH          = `ASC_WIDTH_DEF,
    parameter asc_rep_t REPRESENTATION = ASC_REP_UNSIGNED
) (
    // check sampling only, no datapath state uses these
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // operands
    input  wire logic [WIDTH-1:0] dataa,
    input  wire logic [WIDTH-1:0] datab,
    // arithmetic control, defaults apply when left open
    input  wire logic             add_sub  = `ASC_ADD_SUB_DEF,
    input  wire logic             carry_in = `ASC_CARRY_IN_DEF,
    // arithmetic results
    output logic      [WIDTH-1:0] sum,
    output logic                  carry_out,
    output logic                  overflow,
    // comparison results
    output logic                  a_lt_b,
    output logic                  a_eq_b,
    output logic                  a_gt_b
);

    // refuse illegal parameter settings at elaboration
    generate
        // RULE1: width floor check
        if (WIDTH < `ASC_WIDTH_MIN) begin : g_bad_width
            $error("operand width must be at least two bits");
        end
        // RULE7: only unsigned accepted
        if (REPRESENTATION != ASC_REP_UNSIGNED) begin : g_bad_rep
            $error("only unsigned representation is supported");
        end
    endgenerate

    logic [WIDTH:0] wide_add;   // sum with carry bit on top
    logic [WIDTH:0] wide_sub;   // difference with borrow bit on top
    logic [WIDTH:0] carry_ext;  // carry input widened

    // widened add and subtract, the top bit catches wrap-around
    always_comb begin
        carry_ext = {{WIDTH{1'b0}}, carry_in};
        // RULE3: carry takes part
        // RULE4: plus path
        wide_add  = {1'b0, dataa} + {1'b0, datab} + carry_ext;
        // RULE4: minus path
        wide_sub  = {1'b0, dataa} - {1'b0, datab} - carry_ext;
    end

    // result selection and flags
    always_comb begin
        // RULE2: select steers operation
        if (add_sub == `ASC_SEL_ADD) begin
            // RULE8: low bits wrap
            sum       = wide_add[WIDTH-1:0];
            // RULE5: carry out of width
            carry_out = wide_add[WIDTH];
        end else begin
            sum       = wide_sub[WIDTH-1:0];
            // RULE5: borrow out of width
            carry_out = wide_sub[WIDTH];
        end
        // RULE6: signed-style hint only
        if (add_sub == `ASC_SEL_ADD) begin
            overflow = (dataa[WIDTH-1] == datab[WIDTH-1])
                     && (sum[WIDTH-1] != dataa[WIDTH-1]);
        end else begin
            overflow = (dataa[WIDTH-1] != datab[WIDTH-1])
                     && (sum[WIDTH-1] != dataa[WIDTH-1]);
        end
    end

    // unsigned magnitude compare
    always_comb begin
        // RULE9: less-than
        a_lt_b = (dataa < datab);
        // RULE10: equality
        a_eq_b = (dataa == datab);
        // RULE11: greater-than
        a_gt_b = (dataa > datab);
    end

    // checks below are sampled on core_clk and held off in reset
    // the references are built apart from the datapath expressions so
    // that a slip in one is not copied into the other

    logic [WIDTH+1:0] ref_add;  // independent reference sum
    logic [WIDTH+1:0] ref_sub;  // independent reference difference
    logic [WIDTH+1:0] max_val;  // largest representable value
    logic [WIDTH:0]   ref_diff; // a minus b alone, borrow on top
    logic [WIDTH+1:0] ref_sadd; // two's complement sum, sign extended
    logic [WIDTH+1:0] ref_ssub; // two's complement difference
    logic             ref_sovf; // signed range exceeded by chosen op

    // unsigned references, two spare bits (one on ref_diff) keep every carry visible
    always_comb begin
        ref_add  = {2'h0, dataa} + {2'h0, datab}
                 + {{(WIDTH+1){1'b0}}, carry_in};
        ref_sub  = {2'h0, dataa} - {2'h0, datab}
                 - {{(WIDTH+1){1'b0}}, carry_in};
        max_val  = {2'h0, {WIDTH{1'b1}}};
        ref_diff = {1'b0, dataa} - {1'b0, datab};
    end

    // signed references for the overflow hint only
    always_comb begin
        ref_sadd = {{2{dataa[WIDTH-1]}}, dataa}
                 + {{2{datab[WIDTH-1]}}, datab}
                 + {{(WIDTH+1){1'b0}}, carry_in};
        ref_ssub = {{2{dataa[WIDTH-1]}}, dataa}
                 - {{2{datab[WIDTH-1]}}, datab}
                 - {{(WIDTH+1){1'b0}}, carry_in};
        // out of range when the two top result bits disagree
        if (add_sub == `ASC_SEL_ADD) begin
            ref_sovf = (ref_sadd[WIDTH] != ref_sadd[WIDTH-1]);
        end else begin
            ref_sovf = (ref_ssub[WIDTH] != ref_ssub[WIDTH-1]);
        end
    end

    // operation and carry conditions shared by the properties
    sequence s_adding;
        add_sub == `ASC_SEL_ADD;
    endsequence

    sequence s_subtracting;
        add_sub == `ASC_SEL_SUB;
    endsequence

    sequence s_carry_low;
        carry_in == 1'b0;
    endsequence

    sequence s_carry_high;
        carry_in == 1'b1;
    endsequence

    property p_add_result;
        @(posedge core_clk) disable iff (!resetn)
        s_adding |-> (sum == ref_add[WIDTH-1:0]);
    endproperty
    a_add_result: assert property (p_add_result) // RULE4
        else $error("sum differs from a plus b plus carry");

    property p_sub_result;
        @(posedge core_clk) disable iff (!resetn)
        s_subtracting |-> (sum == ref_sub[WIDTH-1:0]);
    endproperty
    a_sub_result: assert property (p_sub_result) // RULE2
        else $error("difference differs from a minus b minus carry");

    property p_add_carry;
        @(posedge core_clk) disable iff (!resetn)
        s_adding |-> (carry_out == (ref_add > max_val));
    endproperty
    a_add_carry: assert property (p_add_carry) // RULE5
        else $error("carry out does not match unsigned overflow");

    property p_sub_borrow;
        @(posedge core_clk) disable iff (!resetn)
        s_subtracting |->
            (carry_out == ({2'h0, dataa} < ({2'h0, datab}
                          + {{(WIDTH+1){1'b0}}, carry_in})));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) // RULE5
        else $error("borrow out does not match unsigned underflow");

    property p_wrap;
        @(posedge core_clk) disable iff (!resetn)
        (s_adding and (ref_add > max_val)) |->
            (sum == (ref_add - max_val - 1'b1)) && carry_out;
    endproperty
    a_wrap: assert property (p_wrap) // RULE8
        else $error("overflowing sum did not wrap");

    property p_carry_in_effect;
        @(posedge core_clk) disable iff (!resetn)
        (s_adding and carry_in == 1'b0) |->
            (sum == dataa + datab);
    endproperty
    a_carry_in_effect: assert property (p_carry_in_effect) // RULE3
        else $error("sum moved with carry input low");

    property p_less;
        @(posedge core_clk) disable iff (!resetn)
        a_lt_b == ref_diff[WIDTH];
    endproperty
    a_less: assert property (p_less) // RULE9
        else $error("less-than output wrong");

    property p_equal;
        @(posedge core_clk) disable iff (!resetn)
        a_eq_b == ((dataa ^ datab) == '0);
    endproperty
    a_equal: assert property (p_equal) // RULE10
        else $error("equal output wrong");

    property p_greater;
        @(posedge core_clk) disable iff (!resetn)
        a_gt_b == (datab < dataa);
    endproperty
    a_greater: assert property (p_greater) // RULE11
        else $error("greater-than output wrong");

    property p_one_hot_compare;
        @(posedge core_clk) disable iff (!resetn)
        $onehot({a_lt_b, a_eq_b, a_gt_b});
    endproperty
    a_one_hot_compare: assert property (p_one_hot_compare) // RULE9
        else $error("compare outputs not exactly one high");

    property p_same_cycle;
        @(posedge core_clk) disable iff (!resetn)
        ($changed(dataa) && add_sub == `ASC_SEL_ADD && carry_in == 1'b0)
            |-> (sum == dataa + datab);
    endproperty
    a_same_cycle: assert property (p_same_cycle) // RULE12
        else $error("result lags its inputs");

    // subtract without carry is the plain difference
    property p_sub_carry_low;
        @(posedge core_clk) disable iff (!resetn)
        (s_subtracting and s_carry_low) |-> (sum == dataa - datab);
    endproperty
    a_sub_carry_low: assert property (p_sub_carry_low) // RULE3
        else $error("difference moved with carry input low");

    // a high carry adds exactly one
    property p_add_carry_high;
        @(posedge core_clk) disable iff (!resetn)
        (s_adding and s_carry_high) |-> (sum == dataa + datab + 1'b1);
    endproperty
    a_add_carry_high: assert property (p_add_carry_high) // RULE3
        else $error("carry input high did not add one");

    // a high carry takes exactly one more away
    property p_sub_carry_high;
        @(posedge core_clk) disable iff (!resetn)
        (s_subtracting and s_carry_high) |->
            (sum == dataa - datab - 1'b1);
    endproperty
    a_sub_carry_high: assert property (p_sub_carry_high) // RULE3
        else $error("carry input high did not take one away");

    // a sum that fits leaves carry out low and the value whole
    property p_no_wrap;
        @(posedge core_clk) disable iff (!resetn)
        (s_adding and (ref_add <= max_val)) |->
            !carry_out && (sum == ref_add[WIDTH-1:0]);
    endproperty
    a_no_wrap: assert property (p_no_wrap) // RULE5
        else $error("carry out set on a sum that fits");

    // a difference at or above zero has no borrow
    property p_no_borrow;
        @(posedge core_clk) disable iff (!resetn)
        (s_subtracting and (ref_sub <= max_val)) |-> !carry_out;
    endproperty
    a_no_borrow: assert property (p_no_borrow) // RULE5
        else $error("borrow out set on a difference that fits");

    // inverse of less-than is greater-or-equal
    property p_not_less;
        @(posedge core_clk) disable iff (!resetn)
        (!a_lt_b) == (datab <= dataa);
    endproperty
    a_not_less: assert property (p_not_less) // RULE9
        else $error("inverse of less-than is not greater-or-equal");

    // inverse of equal is not-equal
    property p_not_equal;
        @(posedge core_clk) disable iff (!resetn)
        (!a_eq_b) == (dataa != datab);
    endproperty
    a_not_equal: assert property (p_not_equal) // RULE10
        else $error("inverse of equal is not not-equal");

    // inverse of greater-than is less-or-equal
    property p_not_greater;
        @(posedge core_clk) disable iff (!resetn)
        (!a_gt_b) == (dataa <= datab);
    endproperty
    a_not_greater: assert property (p_not_greater) // RULE11
        else $error("inverse of greater-than is not less-or-equal");

    // overflow hint tracks the signed range of the chosen operation
    property p_overflow_hint;
        @(posedge core_clk) disable iff (!resetn)
        overflow == ref_sovf;
    endproperty
    a_overflow_hint: assert property (p_overflow_hint) // RULE6
        else $error("overflow hint differs from signed range check");

endmodule

// *** asc_user_sink.sv ***
// consumer model that registers the datapath sum, carry out and compare results
`timescale 1ns/1ps
module asc_user_sink #(
    parameter int WIDTH = 8
) (
    // clock
    input  wire logic             core_clk,
    // results from the datapath
    input  wire logic [WIDTH-1:0] sum,
    input  wire logic             carry_out,
    input  wire logic             a_lt_b,
    input  wire logic             a_eq_b,
    input  wire logic             a_gt_b,
    // captured copy for the bench
    output logic      [WIDTH-1:0] cap_sum,
    output logic      [3:0]       cap_flag
);
    // results are taken like any downstream register would take them
    always_ff @(posedge core_clk) begin
        cap_sum  <= sum;
        cap_flag <= {carry_out, a_lt_b, a_eq_b, a_gt_b};
    end
endmodule

// *** tb_asc_datapath.sv ***
// self-checking bench for the add/subtract and compare datapath
`timescale 1ns/1ps
module tb_asc_datapath;
    import asc_pkg::*;
    // stimulus and observed results
    logic       core_clk   = 1'b0;
    logic       resetn     = 1'b0;
    logic [7:0] dataa      = 8'h00;
    logic [7:0] datab      = 8'h00;
    logic       add_sub    = 1'b1;
    logic       carry_in   = 1'b0;
    logic [7:0] sum, o_sum, cap_sum;
    logic       carry_out, a_lt_b, a_eq_b, a_gt_b, ovf;
    logic       o_cout, o_lt, o_eq, o_gt;
    logic [3:0] cap_flag;
    int         err_count  = 0;
    int         n_compared = 0;

    asc_datapath #(.WIDTH(8), .REPRESENTATION(ASC_REP_UNSIGNED)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .dataa(dataa),
        .datab(datab), .add_sub(add_sub), .carry_in(carry_in),
        .sum(sum), .carry_out(carry_out), .overflow(ovf),
        .a_lt_b(a_lt_b), .a_eq_b(a_eq_b), .a_gt_b(a_gt_b));
    // select and carry left open on purpose to see their defaults
    asc_datapath #(.WIDTH(8), .REPRESENTATION(ASC_REP_UNSIGNED)) i_dut_open (
        .core_clk(core_clk), .resetn(resetn), .dataa(dataa),
        .datab(datab), .sum(o_sum), .carry_out(o_cout), .overflow(),
        .a_lt_b(o_lt), .a_eq_b(o_eq), .a_gt_b(o_gt));
    asc_user_sink #(.WIDTH(8)) i_sink (
        .core_clk(core_clk), .sum(sum), .carry_out(carry_out),
        .a_lt_b(a_lt_b), .a_eq_b(a_eq_b), .a_gt_b(a_gt_b),
        .cap_sum(cap_sum), .cap_flag(cap_flag));

    // 20 MHz clock
    initial forever #25 core_clk = ~core_clk;

    task automatic cmp_w(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_f(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // drive one operation, check it at once and after downstream capture
    task automatic apply(input logic [7:0] a, b, input logic s, c);
        logic [8:0] e;
        logic [8:0] g;
        logic [3:0] f;
        int         sr;
        @(posedge core_clk);
        dataa    <= a;
        datab    <= b;
        add_sub  <= s;
        carry_in <= c;
        e = s ? ({1'b0, a} + b + c) : ({1'b0, a} - b - c);
        g = {1'b0, a} + b;
        f = {e[8], a < b, a == b, a > b};
        // signed value of the same operation, for the overflow hint
        sr = s ? (int'($signed(a)) + int'($signed(b)) + int'(c))
               : (int'($signed(a)) - int'($signed(b)) - int'(c));
        #1;
        cmp_w(sum, e[7:0]);
        cmp_w(o_sum, g[7:0]);
        cmp_f({o_cout, o_lt, o_eq, o_gt}, {g[8], f[2:0]});
        cmp_f({3'h0, ovf}, {3'h0, (sr > 127) || (sr < -128)});
        @(posedge core_clk);
        #1;
        cmp_w(cap_sum, e[7:0]);
        cmp_f(cap_flag, f);
    endtask

    // sums past the top wrap around with carry out
    task automatic t_wrap();
        apply(8'hFF, 8'h01, 1'b1, 1'b0);
        apply(8'hFF, 8'hFF, 1'b1, 1'b1);
        apply(8'h80, 8'h80, 1'b1, 1'b0);
    endtask

    // subtraction with and without borrow in
    task automatic t_sub();
        apply(8'hFF, 8'h01, 1'b0, 1'b0);
        apply(8'h01, 8'h02, 1'b0, 1'b0);
        apply(8'h05, 8'h05, 1'b0, 1'b1);
        apply(8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    // sweep below, equal and above a fixed second operand
    task automatic t_cmp();
        for (int i = 0; i < 16; i++) begin
            apply(8'(i * 17), 8'h44, i[0], i[1]);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        t_wrap();
        t_sub();
        t_cmp();
        summarize();
    end

    // watchdog well past the expected run length
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule
